// *** bench/rfq_ring_qualifier_assertions.sv ***
`timescale 1ns/1ps
module rfq_ring_qualifier_chk (
  input wire       mclk,
  input wire       rst_n,
  input wire [2:0] regAddr,
  input wire [7:0] regWrData,
  input wire       regWr,
  input wire       regRd,
  input wire [7:0] regRdData,
  input wire       lineEvent,
  input wire       ringActive,
  input wire       tooFastPulse,
  input wire       tooSlowPulse,
  input wire       ringEndPulse,
  input wire       irq
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  AST_FAST_CAUSE: assert property (tooFastPulse |-> $past(lineEvent))
    else $error("fast flag without event");
  AST_SLOW_CAUSE: assert property (tooSlowPulse |-> $past(lineEvent))
    else $error("slow flag without event");
  AST_FAST_SLOW: assert property (!(tooFastPulse && tooSlowPulse))
    else $error("fast and slow together");
  AST_RING_RISE: assert property ($rose(ringActive) |-> $past(lineEvent))
    else $error("ring start without event");
  AST_RING_END: assert property ($fell(ringActive) |-> ringEndPulse)
    else $error("ring dropped without end flag");
  AST_FAST_ONE: assert property (tooFastPulse |=> !tooFastPulse)
    else $error("fast flag too long");
  AST_END_ONE: assert property (ringEndPulse |=> !ringEndPulse)
    else $error("end flag too long");
  AST_END_QUIET: assert property (ringEndPulse && !tooFastPulse && !tooSlowPulse |-> !$past(lineEvent))
    else $error("timeout end on event");
endmodule
bind rfq_ring_qualifier rfq_ring_qualifier_chk u_chk (.mclk(mclk), .rst_n(rst_n), .regAddr(regAddr),
  .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .lineEvent(lineEvent),
  .ringActive(ringActive), .tooFastPulse(tooFastPulse), .tooSlowPulse(tooSlowPulse),
  .ringEndPulse(ringEndPulse), .irq(irq));

// *** bench/test_ring_frequency_qualifier.sv ***
`timescale 1ns/1ps
module test_ring_frequency_qualifier;
  logic       mclk = 0;
  logic       rst_n = 0;
  logic       regWr = 0;
  logic       regRd = 0;
  logic       lineEvent = 0;
  logic [2:0] regAddr = 0;
  logic [7:0] regWrData = 0;
  wire  [7:0] regRdData;
  wire        ringActive, tooFastPulse, tooSlowPulse, ringEndPulse, irq;
  wire  [7:0] pv = {4'h0, ringActive, ringEndPulse, tooSlowPulse, tooFastPulse};
  integer     fails = 0;
  integer     nTests = 0;
  integer     i, n;
  int         cd[4] = '{0, 1, 2, 15};
  int         tmo[4] = '{80, 128, 256, 1920};
  always #2 mclk = ~mclk;
  rfq_ring_qualifier #(.UNIT_CYCLES(20), .MS_CYCLES(10)) u_dut (.mclk(mclk), .rst_n(rst_n),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .lineEvent(lineEvent), .ringActive(ringActive), .tooFastPulse(tooFastPulse),
    .tooSlowPulse(tooSlowPulse), .ringEndPulse(ringEndPulse), .irq(irq));
  ////////////////////////////////////////
  task chk(input [7:0] g, input [7:0] e);
    nTests++;
    if (g !== e)
    begin
      fails++;
      $display("Error at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task wt(input integer c);
    repeat (c) @(posedge mclk);
  endtask
  task wr(input [2:0] a, input [7:0] d);
    @(posedge mclk);
    regWr <= 1;
    regAddr <= a;
    regWrData <= d;
    @(posedge mclk);
    regWr <= 0;
    #1;
  endtask
  task rd(input [2:0] a, input [7:0] e);
    @(posedge mclk);
    regRd <= 1;
    regAddr <= a;
    @(posedge mclk);
    regRd <= 0;
    #1 chk(regRdData, e);
  endtask
  task ev;
    @(posedge mclk);
    lineEvent <= 1;
    @(posedge mclk);
    lineEvent <= 0;
    #1;
  endtask
  task complete_run;
    $display("fails %0d checks %0d", fails, nTests);
    if (fails == 0 && nTests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////
  initial
  begin
    #200000;
    fails++;
    complete_run;
  end
  initial
  begin
    wt(12);
    rst_n <= 1;
    rd(3'h0, 8'h19);
    rd(3'h1, 8'h16);
    rd(3'h2, 8'h00);
    rd(3'h3, 8'h00);
    rd(3'h5, 8'h00);
    wr(3'h0, 8'hff);
    rd(3'h0, 8'h3f);
    wr(3'h0, 8'h06);
    wr(3'h1, 8'h02);
    ev;
    wt(48);
    rd(3'h4, 8'h44);
    ev;
    chk(pv, 8'h01);
    wt(88);
    ev;
    chk(pv, 8'h08);
    rd(3'h2, 8'h05);
    chk({7'h0, irq}, 8'h00);
    wr(3'h3, 8'h04);
    chk({7'h0, irq}, 8'h01);
    wr(3'h2, 8'h05);
    chk({7'h0, irq}, 8'h00);
    rd(3'h2, 8'h00);
    wt(150);
    ev;
    chk(pv, 8'h06);
    for (i = 0; i < 4; i++)
    begin
      wr(3'h1, {cd[i][3:0], 4'h2});
      ev;
      wt(88);
      ev;
      chk(pv, 8'h08);
      n = 0;
      while (!ringEndPulse && n < 20000)
      begin
        @(posedge mclk);
        #1 n++;
      end
      chk(pv, 8'h04);
      chk({7'h0, n >= tmo[i] * 10 - 2 && n <= tmo[i] * 10 + 2}, 8'h01);
    end
    complete_run;
  end
endmodule

// *** hw/rfq_consts.vh ***
`ifndef RFQ_CONSTS_VH
`define RFQ_CONSTS_VH

// register offsets
`define RFQ_ADDR_SETTING    3'h0
`define RFQ_ADDR_CTRL_THREE 3'h1
`define RFQ_ADDR_STATUS   3'h2
`define RFQ_ADDR_MASK     3'h3
`define RFQ_ADDR_STATE    3'h4

// reset values
`define RFQ_SETTING_RST    6'h19
`define RFQ_CTRL_THREE_RST 8'h16
`define RFQ_MASK_RST      4'h0

// field positions
`define RFQ_MAXCNT_MSB    3
`define RFQ_MAXCNT_LSB    0
`define RFQ_TOSEL_MSB     7
`define RFQ_TOSEL_LSB     4

// status bits
`define RFQ_ST_FAST       0
`define RFQ_ST_SLOW       1
`define RFQ_ST_QUAL       2
`define RFQ_ST_END        3

// timing
`define RFQ_CLK_MHZ       250
`define RFQ_UNIT_MS       2
`define RFQ_MS_MS         1
`define RFQ_UNIT_CYC      (`RFQ_UNIT_MS * 1000 * `RFQ_CLK_MHZ)
`define RFQ_MS_CYC        (`RFQ_MS_MS * 1000 * `RFQ_CLK_MHZ)
`define RFQ_TO_CODE0_MS   11'h050
`define RFQ_TO_STEP_SHIFT 7

`endif

// *** hw/rfq_ring_qualifier.v ***
// Summary of operation
// - a four-bit max-count field sets the highest accepted ring frequency.
// - each line event loads the countdown from ring-assertion setting; it decrements regularly.
// - at a later event, timer above max-count invalidates the ring as too fast.
// - setting minus max-count is the least event spacing, in 2.0 ms units.
// - event after timer expiry invalidates as too slow; setting is six bits.
//
// Decided for this implementation: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`include "rfq_consts.vh"
module rfq_ring_qualifier #(
  parameter UNIT_CYCLES = `RFQ_UNIT_CYC,
  parameter MS_CYCLES   = `RFQ_MS_CYC
) (
  input  wire       mclk,
  input  wire       rst_n,
  input  wire [2:0] regAddr,
  input  wire [7:0] regWrData,
  input  wire       regWr,
  input  wire       regRd,
  output reg  [7:0] regRdData,
  input  wire       lineEvent,
  output wire       ringActive,
  output reg        tooFastPulse,
  output reg        tooSlowPulse,
  output reg        ringEndPulse,
  output wire       irq
);

  //////////////////////////////////////////////////////////////////////////////
  // states

  localparam [2:0] ST_IDLE    = 3'b001;
  localparam [2:0] ST_ARMED   = 3'b010;
  localparam [2:0] ST_RINGING = 3'b100;

  //////////////////////////////////////////////////////////////////////////////
  // declarations

  reg  [5:0]  assertSetting_q;
  reg  [7:0]  ctrlThree_q;
  reg  [3:0]  status_q;
  reg  [3:0]  status_d;
  reg  [3:0]  mask_q;
  reg  [2:0]  state_q;
  reg  [2:0]  state_d;
  reg  [5:0]  timer_q;
  reg  [5:0]  timer_d;
  reg  [10:0] msCount_q;
  reg  [10:0] timeoutMs;
  reg  [3:0]  evtSet;
  reg         endEvt;
  wire        unitTick;
  wire        msTick;
  wire [3:0]  ringMaxCount;
  wire [3:0]  ringEndTimeoutSelect;
  wire        timerExpired;
  wire        timerTooHigh;
  wire        timedOut;
  wire        wrSetting;
  wire        wrCtrlThree;
  wire        wrStatus;
  wire        wrMask;

  assign ringMaxCount         = ctrlThree_q[`RFQ_MAXCNT_MSB:`RFQ_MAXCNT_LSB];
  assign ringEndTimeoutSelect = ctrlThree_q[`RFQ_TOSEL_MSB:`RFQ_TOSEL_LSB];
  assign timerExpired         = (timer_q == 6'h00);
  assign timerTooHigh         = (timer_q > {2'h0, ringMaxCount});
  assign timedOut             = (msCount_q >= timeoutMs);
  assign ringActive           = state_q[2];
  assign irq                  = |(status_q & mask_q);
  assign wrSetting            = regWr && (regAddr == `RFQ_ADDR_SETTING);
  assign wrCtrlThree          = regWr && (regAddr == `RFQ_ADDR_CTRL_THREE);
  assign wrStatus             = regWr && (regAddr == `RFQ_ADDR_STATUS);
  assign wrMask               = regWr && (regAddr == `RFQ_ADDR_MASK);

  //////////////////////////////////////////////////////////////////////////////
  // time bases, realigned at each line event

  rfq_tick_div #(
    .PERIOD (UNIT_CYCLES)
  ) uUnitTick (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .restart (lineEvent),
    .tick    (unitTick)
  );

  rfq_tick_div #(
    .PERIOD (MS_CYCLES)
  ) uMsTick (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .restart (lineEvent),
    .tick    (msTick)
  );

  //////////////////////////////////////////////////////////////////////////////
  // end-of-ring delay decode

  always @*
  begin
    case (ringEndTimeoutSelect)
      4'h0:    timeoutMs = `RFQ_TO_CODE0_MS;
      default: timeoutMs = {ringEndTimeoutSelect, 7'h00};
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // qualification state machine

  always @*
  begin
    state_d = state_q;
    timer_d = timer_q;
    evtSet  = 4'h0;
    endEvt  = 1'b0;
    if (unitTick && !timerExpired)
    begin
      timer_d = timer_q - 6'h01;
    end
    case (state_q)
      ST_IDLE:
      begin
        if (lineEvent)
        begin
          timer_d = assertSetting_q;
          state_d = ST_ARMED;
        end
      end
      ST_ARMED, ST_RINGING:
      begin
        if (lineEvent)
        begin
          timer_d = assertSetting_q;
          if (timerExpired)
          begin
            evtSet[`RFQ_ST_SLOW] = 1'b1;
            state_d = ST_ARMED;
          end
          else if (timerTooHigh)
          begin
            evtSet[`RFQ_ST_FAST] = 1'b1;
            state_d = ST_ARMED;
          end
          else
          begin
            // spacing at least setting minus max-count units
            if (state_q == ST_ARMED)
            begin
              evtSet[`RFQ_ST_QUAL] = 1'b1;
            end
            state_d = ST_RINGING;
          end
          if ((timerExpired || timerTooHigh) && state_q == ST_RINGING)
          begin
            evtSet[`RFQ_ST_END] = 1'b1;
            endEvt = 1'b1;
          end
        end
        else if (timedOut)
        begin
          state_d = ST_IDLE;
          if (state_q == ST_RINGING)
          begin
            evtSet[`RFQ_ST_END] = 1'b1;
            endEvt = 1'b1;
          end
        end
      end
      default:
      begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= ST_IDLE;
      timer_q <= 6'h00;
    end
    else
    begin
      state_q <= state_d;
      timer_q <= timer_d;
    end
  end

  // event flags, one cycle each
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tooFastPulse <= 1'b0;
      tooSlowPulse <= 1'b0;
      ringEndPulse <= 1'b0;
    end
    else
    begin
      tooFastPulse <= evtSet[`RFQ_ST_FAST];
      tooSlowPulse <= evtSet[`RFQ_ST_SLOW];
      ringEndPulse <= endEvt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // milliseconds since the last line event, saturating

  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      msCount_q <= 11'h000;
    end
    else if (lineEvent)
    begin
      msCount_q <= 11'h000;
    end
    else if (msTick && (msCount_q != 11'h7ff))
    begin
      msCount_q <= msCount_q + 11'h001;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // register file and sticky status

  always @*
  begin
    status_d = status_q;
    if (wrStatus)
    begin
      status_d = status_q & ~regWrData[3:0];
    end
    status_d = status_d | evtSet;
  end

  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      status_q <= 4'h0;
    end
    else
    begin
      status_q <= status_d;
    end
  end

  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      assertSetting_q <= `RFQ_SETTING_RST;
    end
    else if (wrSetting)
    begin
      assertSetting_q <= regWrData[5:0];
    end
  end

  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrlThree_q <= `RFQ_CTRL_THREE_RST;
    end
    else if (wrCtrlThree)
    begin
      ctrlThree_q <= regWrData;
    end
  end

  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mask_q <= `RFQ_MASK_RST;
    end
    else if (wrMask)
    begin
      mask_q <= regWrData[3:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read data, held for one cycle after the strobe

  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      regRdData <= 8'h00;
    end
    else if (regRd)
    begin
      case (regAddr)
        `RFQ_ADDR_SETTING:    regRdData <= {2'h0, assertSetting_q};
        `RFQ_ADDR_CTRL_THREE: regRdData <= ctrlThree_q;
        `RFQ_ADDR_STATUS:     regRdData <= {4'h0, status_q};
        `RFQ_ADDR_MASK:       regRdData <= {4'h0, mask_q};
        `RFQ_ADDR_STATE:      regRdData <= {state_q[2], state_q[1], timer_q};
        default:              regRdData <= 8'h00;
      endcase
    end
    else
    begin
      regRdData <= 8'h00;
    end
  end

endmodule

// *** hw/rfq_tick_div.v ***
`timescale 1ns/1ps
module rfq_tick_div #(
  parameter PERIOD = 500000
) (
  input  wire mclk,
  input  wire rst_n,
  input  wire restart,
  output reg  tick
);
  localparam integer LAST_FULL = PERIOD - 1;
  localparam [19:0]  LAST      = LAST_FULL[19:0];

  reg [19:0] cnt_q;

  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q <= 20'h00000;
      tick  <= 1'b0;
    end
    else if (restart)
    begin
      cnt_q <= 20'h00000;
      tick  <= 1'b0;
    end
    else if (cnt_q >= LAST)
    begin
      cnt_q <= 20'h00000;
      tick  <= 1'b1;
    end
    else
    begin
      cnt_q <= cnt_q + 20'h00001;
      tick  <= 1'b0;
    end
  end
endmodule
